// File: drive_plant_model.sv
// Drive plant model feeding fault, speed and line rate
module drive_plant_model (
  // Bench controls
  input wire logic        aclk,
  input wire logic        fault_req,
  input wire logic [15:0] speed_set,
  input wire logic [1:0]  rate_set,
  // Drive side
  output logic            drive_fault = 1'h0,
  output logic [15:0]     actual_speed = 16'h0,
  output logic [1:0]      detected_rate = 2'h0
);
  always @(posedge aclk) begin
    drive_fault   <= fault_req;
    actual_speed  <= speed_set;
    detected_rate <= rate_set;
  end
endmodule

// File: fieldbus_command_supervisor.sv
// Command frame interpreter, status frame builder and silence supervisor
// Summary of operation
// - Command: bit0 run, bit2 clear, speed bytes2-3
// - Run bit zero stops, one starts
// - Clear bit one clears latched trip
// - Status: bit0 fault, bit2 running, speed
// - Fault flag follows drive fault or latched trip
// - Running flag follows active start
// - Speeds 16-bit, 16384 is full scale
// - Line rate code 20, 21, 22
// - Default setting detects rate automatically
// - Interval 1 to 99 seconds, default 1
// - Reaction code 0 to 7, default off
// - Counter armed by first valid command
// - Silence on expiry or policy 3 zero
// - Valid command resumes; trip needs clear
// - Local site ends silence state
// - Authority disabled ends silence state
// - Reaction off resumes with last command
// - Leaving silence disarms counter until valid
// - Reactions other than profile four last until communication resumes
// - Profile four stays after resumption
// - Validity policy code 0 to 3
// - Policy 1 ignores frame when bit zero
// - Policy 2 ignores on one; zeros coast
// - Local site blocks network commands
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`include "fieldbus_command_supervisor_cfg.svh"
module fieldbus_command_supervisor
  import fieldbus_command_supervisor_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Drive side inputs, asynchronous
  input  wire logic        drive_fault,
  input  wire logic [15:0] actual_speed,
  input  wire logic [1:0]  detected_rate,
  // Drive side outputs
  output logic             run_forward,
  output logic             coast,
  output logic [15:0]      speed_reference,
  output logic             trip_latched,
  output logic             profile4_active,
  output logic             network_control,
  output logic             silence_active
);

  // ===================================================================
  // State
  typedef struct packed {
    logic                 awready;
    logic                 wready;
    logic                 aw_held;
    logic                 w_held;
    logic [7:0]           waddr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic [1:0]           fault_s1;
    logic                 fault_s2;
    logic [15:0]          speed_s1;
    logic [15:0]          speed_s2;
    logic [1:0]           rate_s1;
    logic [1:0]           rate_s2;
    silence_reaction_type reaction;
    validity_policy_type  policy;
    logic [1:0]           rate_sel;
    logic                 local_site;
    logic                 authority;
    logic [6:0]           interval;
    logic [15:0]          inch;
    logic [31:0]          frame;
    logic                 run_cmd;
    logic [15:0]          ref_cmd;
    link_state_type       link;
    logic                 armed;
    logic [31:0]          tick_cnt;
    logic [6:0]           sec_cnt;
    logic                 run_forward;
    logic                 coast;
    logic [15:0]          speed_reference;
    logic                 trip_latched;
    logic                 profile4_active;
    logic                 network_control;
    logic                 silence_active;
  } state_type;

  state_type s;
  state_type next_s;

  // ===================================================================
  // Next state
  always_comb begin
    logic        wr_fire;
    logic        cmd_wr;
    logic        bit_ok;
    logic        accept;
    logic        go_silent;
    logic        leave;
    logic        tick;
    logic [31:0] rd;
    logic [31:0] ctl;
    logic [7:0]  rate_code;
    logic [6:0]  iv;
    wr_fire   = 1'b0;
    cmd_wr    = 1'b0;
    bit_ok    = 1'b0;
    accept    = 1'b0;
    go_silent = 1'b0;
    leave     = 1'b0;
    tick      = 1'b0;
    rd        = 32'h0000_0000;
    ctl       = 32'h0000_0000;
    rate_code = 8'h00;
    iv        = 7'h00;
    next_s    = s;

    // Two-flop synchronisers for drive side inputs
    next_s.fault_s1 = {1'b0, drive_fault};
    next_s.fault_s2 = s.fault_s1[0];
    next_s.speed_s1 = actual_speed;
    next_s.speed_s2 = s.speed_s1;
    next_s.rate_s1  = detected_rate;
    next_s.rate_s2  = s.rate_s1;

    // Rate code: zero selects detection, else fixed rate minus one
    if (s.rate_sel == 2'h0) begin
      rate_code = `RATE_CODE_BASE + {6'h00, s.rate_s2};
    end else begin
      rate_code = `RATE_CODE_BASE + {6'h00, s.rate_sel - 2'h1};
    end

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.awready = 1'b0;
      next_s.waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wready = 1'b0;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      wr_fire        = 1'b1;
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = 2'b00;
      case (s.waddr)
        {4'h0, `OFS_CONTROL}: begin
          if (s.wstrb[0]) begin
            next_s.reaction = silence_reaction_type'(s.wdata[2:0]);
            next_s.policy   = validity_policy_type'(s.wdata[5:4]);
          end
          if (s.wstrb[1]) begin
            next_s.rate_sel   = s.wdata[9:8];
            next_s.local_site = s.wdata[`CTL_LOCAL_BIT];
            next_s.authority  = s.wdata[`CTL_AUTH_BIT];
          end
          if (s.wstrb[2] && !s.wdata[`CTL_PROF4_BIT]) begin
            next_s.profile4_active = 1'b0;
          end
        end
        {4'h0, `OFS_INTERVAL}: begin
          if (s.wstrb[0]) begin
            iv = s.wdata[6:0];
            if (iv < `MIN_INTERVAL) begin
              iv = `MIN_INTERVAL;
            end else if (iv > `MAX_INTERVAL) begin
              iv = `MAX_INTERVAL;
            end
            next_s.interval = iv;
          end
        end
        {4'h0, `OFS_COMMAND}: begin
          cmd_wr = 1'b1;
        end
        `OFS_INCH: begin
          if (s.wstrb[0]) next_s.inch[7:0] = s.wdata[7:0];
          if (s.wstrb[1]) next_s.inch[15:8] = s.wdata[15:8];
        end
        {4'h0, `OFS_STATUS}, `OFS_SUPER, `OFS_RATE: begin
          next_s.bresp = 2'b10;
        end
        default: begin
          next_s.bresp = 2'b10;
        end
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid  = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready  = 1'b1;
    end

    // Read channel
    ctl = {15'h0000, s.profile4_active, 2'b00, s.authority, s.local_site,
           2'b00, s.rate_sel, 2'b00, s.policy, 1'b0, s.reaction};
    case (s_axi_araddr)
      {4'h0, `OFS_CONTROL}:  rd = ctl;
      {4'h0, `OFS_INTERVAL}: rd = {25'h0000000, s.interval};
      {4'h0, `OFS_COMMAND}:  rd = s.frame;
      {4'h0, `OFS_STATUS}: begin
        rd = {s.speed_s2, 13'h0000, s.run_forward, 1'b0,
              s.fault_s2 | s.trip_latched};
      end
      `OFS_SUPER: begin
        rd = {24'h000000, s.sec_cnt[5:0] == 6'h00 && !s.armed,
              s.coast, s.network_control, s.profile4_active,
              s.trip_latched, s.armed, s.run_forward, s.link};
      end
      `OFS_RATE:  rd = {24'h000000, rate_code};
      `OFS_INCH:  rd = {16'h0000, s.inch};
      default:    rd = 32'h0000_0000;
    endcase
    if (s_axi_arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rdata   = rd;
      next_s.rresp   = (s_axi_araddr[1:0] != 2'b00 ||
                        s_axi_araddr > `OFS_INCH) ? 2'b10 : 2'b00;
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end

    // Command frame acceptance
    if (cmd_wr) begin
      next_s.frame = s.wdata;
      case (s.policy)
        POL_IGNORE:  bit_ok = 1'b1;
        POL_ON_ONE:  bit_ok = s.wdata[`CMD_VALID_BIT];
        POL_ON_ZERO: bit_ok = !s.wdata[`CMD_VALID_BIT];
        POL_TIMEOUT: bit_ok = s.wdata[`CMD_VALID_BIT];
        default:     bit_ok = 1'b0;
      endcase
      accept = bit_ok && !s.local_site && s.authority;
    end

    // One-second tick, restarted by every accepted command
    if (accept || !s.armed || s.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      next_s.tick_cnt = 32'h0000_0000;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 32'h0000_0001;
    end
    tick = s.armed && !accept && s.tick_cnt >= 32'(TICK_CYCLES - 1);

    if (accept) begin
      next_s.armed   = 1'b1;
      next_s.sec_cnt = 7'h00;
      next_s.run_cmd = s.wdata[`CMD_RUN_BIT];
      next_s.ref_cmd = s.wdata[`CMD_SPEED_LSB +: 16];
      next_s.coast   = s.policy == POL_ON_ZERO &&
                       s.wdata[15:0] == 16'h0000;
    end else if (tick) begin
      next_s.sec_cnt = s.sec_cnt + 7'h01;
    end

    // Entry into the silence state
    if (s.link == LINK_ONLINE && s.reaction != REACT_OFF &&
        !s.local_site && s.authority) begin
      if (tick && s.sec_cnt + 7'h01 >= s.interval) begin
        go_silent = 1'b1;
      end
      if (cmd_wr && s.policy == POL_TIMEOUT &&
          !s.wdata[`CMD_VALID_BIT]) begin
        go_silent = 1'b1;
      end
    end
    if (go_silent) begin
      next_s.link  = LINK_SILENT;
      next_s.armed = 1'b0;
      if (s.reaction == REACT_TRIP) begin
        next_s.trip_latched = 1'b1;
      end
      if (s.reaction == REACT_PROFILE) begin
        next_s.profile4_active = 1'b1;
      end
    end

    // Exit from the silence state
    if (s.link == LINK_SILENT) begin
      if (s.local_site) begin
        leave = 1'b1;
      end else if (!s.authority) begin
        leave = 1'b1;
      end else if (s.reaction == REACT_OFF) begin
        leave = 1'b1;
      end else if (accept && (s.reaction != REACT_TRIP ||
                              !s.trip_latched ||
                              s.wdata[`CMD_CLEAR_BIT])) begin
        leave = 1'b1;
      end
    end
    if (leave) begin
      next_s.link = LINK_ONLINE;
      if (!accept) begin
        next_s.armed   = 1'b0;
        next_s.sec_cnt = 7'h00;
      end
    end

    // Trip clear by an accepted command; a new trip wins
    if (accept && s.wdata[`CMD_CLEAR_BIT] && !go_silent) begin
      next_s.trip_latched = 1'b0;
    end

    // Outputs of the drive side
    next_s.silence_active  = next_s.link == LINK_SILENT;
    next_s.network_control = !next_s.local_site && next_s.authority &&
                             !(next_s.link == LINK_SILENT &&
                               s.reaction == REACT_RELEASE);
    next_s.run_forward     = next_s.run_cmd && !next_s.coast &&
                             !next_s.trip_latched;
    next_s.speed_reference = next_s.ref_cmd;
    if (next_s.link == LINK_SILENT) begin
      case (s.reaction)
        REACT_HOLD: begin
          next_s.speed_reference = s.speed_reference;
        end
        REACT_STOP, REACT_TRIP: begin
          next_s.run_forward = 1'b0;
        end
        REACT_INCH: begin
          next_s.speed_reference = s.inch;
        end
        REACT_TOP: begin
          next_s.speed_reference = `TOP_SPEED;
        end
        default: begin
          next_s.speed_reference = next_s.ref_cmd;
        end
      endcase
    end
    if (!next_s.network_control) begin
      next_s.run_forward = 1'b0;
    end
  end

  // ===================================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s          <= '0;
      s.awready  <= 1'b1;
      s.wready   <= 1'b1;
      s.arready  <= 1'b1;
      s.reaction <= REACT_OFF;
      s.policy   <= validity_policy_type'(`RST_POLICY);
      s.authority <= 1'b1;
      s.interval <= `RST_INTERVAL;
      s.inch     <= `RST_INCH;
      s.network_control <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ===================================================================
  // Port drive
  assign s_axi_awready   = s.awready;
  assign s_axi_wready    = s.wready;
  assign s_axi_bresp     = s.bresp;
  assign s_axi_bvalid    = s.bvalid;
  assign s_axi_arready   = s.arready;
  assign s_axi_rdata     = s.rdata;
  assign s_axi_rresp     = s.rresp;
  assign s_axi_rvalid    = s.rvalid;
  assign run_forward     = s.run_forward;
  assign coast           = s.coast;
  assign speed_reference = s.speed_reference;
  assign trip_latched    = s.trip_latched;
  assign profile4_active = s.profile4_active;
  assign network_control = s.network_control;
  assign silence_active  = s.silence_active;

endmodule

// File: fieldbus_command_supervisor_cfg.svh
// Offsets, field positions, reset values and timing of the supervisor
`ifndef FIELDBUS_COMMAND_SUPERVISOR_CFG_SVH
`define FIELDBUS_COMMAND_SUPERVISOR_CFG_SVH
// =====================================================================
// Register byte offsets
`define OFS_CONTROL   4'h0
`define OFS_INTERVAL  4'h4
`define OFS_COMMAND   4'h8
`define OFS_STATUS    4'hC
// Second page of offsets, upper nibble of the address
`define OFS_SUPER     8'h10
`define OFS_RATE      8'h14
`define OFS_INCH      8'h18
// =====================================================================
// Control register fields
`define CTL_REACT_LSB   0
`define CTL_POLICY_LSB  4
`define CTL_RATE_LSB    8
`define CTL_LOCAL_BIT   12
`define CTL_AUTH_BIT    13
`define CTL_PROF4_BIT   16
// Command frame fields
`define CMD_RUN_BIT     0
`define CMD_CLEAR_BIT   2
`define CMD_VALID_BIT   10
`define CMD_SPEED_LSB   16
// Status frame fields
`define STS_FAULT_BIT   0
`define STS_RUN_BIT     2
`define STS_SPEED_LSB   16
// =====================================================================
// Reset values and constants
`define RST_INTERVAL    7'h01
`define RST_POLICY      2'h1
`define RST_REACT       3'h0
`define RST_INCH        16'h0CCD
`define TOP_SPEED       16'h4000
`define MIN_INTERVAL    7'h01
`define MAX_INTERVAL    7'h63
`define RATE_CODE_BASE  8'h14
// =====================================================================
// Timing
`define SECOND_NS       1000000000
`define CLK_PERIOD_NS   50
`define TICK_CYCLES     (`SECOND_NS / `CLK_PERIOD_NS)
`endif

// File: fieldbus_command_supervisor_checker.sv
// Port assertions for the fieldbus command supervisor
module fieldbus_command_supervisor_checker #(
  parameter int TICK_CYCLES = 10
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Drive side
  input wire logic        run_forward,
  input wire logic        coast,
  input wire logic        trip_latched,
  input wire logic        profile4_active
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ====================================================================
  // Bus handshakes
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("no write answer");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("no read answer");
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("bvalid dropped");
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("rvalid dropped");
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write not blocked");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write not reopened");
  // ====================================================================
  // Drive outputs
  property p_coast_stop;
    coast |-> !run_forward;
  endproperty
  a_coast_stop: assert property (p_coast_stop)
    else $error("coast runs");
  property p_trip_stop;
    trip_latched |-> !run_forward;
  endproperty
  a_trip_stop: assert property (p_trip_stop) else $error("trip runs");
  property p_prof_keep;
    profile4_active |=> profile4_active || $rose(s_axi_bvalid);
  endproperty
  a_prof_keep: assert property (p_prof_keep)
    else $error("profile lost");
endmodule

bind fieldbus_command_supervisor fieldbus_command_supervisor_checker #(
  .TICK_CYCLES(TICK_CYCLES)
) chk_ports (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .run_forward(run_forward), .coast(coast),
  .trip_latched(trip_latched), .profile4_active(profile4_active)
);

// File: fieldbus_command_supervisor_pkg.sv
// Types shared by the fieldbus command supervisor
package fieldbus_command_supervisor_pkg;
  typedef enum logic [2:0] {
    REACT_OFF     = 3'b000,
    REACT_HOLD    = 3'b001,
    REACT_STOP    = 3'b010,
    REACT_INCH    = 3'b011,
    REACT_TOP     = 3'b100,
    REACT_TRIP    = 3'b101,
    REACT_RELEASE = 3'b110,
    REACT_PROFILE = 3'b111
  } silence_reaction_type;
  typedef enum logic [1:0] {
    POL_IGNORE    = 2'b00,
    POL_ON_ONE    = 2'b01,
    POL_ON_ZERO   = 2'b10,
    POL_TIMEOUT   = 2'b11
  } validity_policy_type;
  typedef enum logic [0:0] {
    LINK_ONLINE   = 1'b0,
    LINK_SILENT   = 1'b1
  } link_state_type;
endpackage

// File: test_fieldbus_command_supervisor.sv
// Self-checking bench for the fieldbus command supervisor
module test_fieldbus_command_supervisor
  import fieldbus_command_supervisor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 40;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, fault_req = 1'h0;
  logic [15:0] speed_set = 16'h0, sp, s2;
  logic [1:0]  rate_set = 2'h0;
  wire         awready, wready, bvalid, arready, rvalid, drive_fault;
  wire  [1:0]  bresp, rresp, detected_rate;
  wire  [31:0] rdata;
  wire  [15:0] actual_speed, speed_reference;
  wire         run_forward, coast, trip_latched, profile4_active;
  wire         network_control, silence_active;
  int          n_mismatch = 0, tests_run = 0, seed = 32'h6C83;
  logic [33:0] rq[$], x;
  logic [31:0] mq[$], m;
  logic [1:0]  bq[$];
  always #25 aclk = ~aclk;
  fieldbus_command_supervisor #(.TICK_CYCLES(TICK))
    i_fieldbus_command_supervisor (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .drive_fault(drive_fault), .actual_speed(actual_speed),
    .detected_rate(detected_rate), .run_forward(run_forward),
    .coast(coast), .speed_reference(speed_reference),
    .trip_latched(trip_latched), .profile4_active(profile4_active),
    .network_control(network_control), .silence_active(silence_active));
  drive_plant_model i_drive_plant_model (
    .aclk(aclk), .fault_req(fault_req), .speed_set(speed_set),
    .rate_set(rate_set), .drive_fault(drive_fault),
    .actual_speed(actual_speed), .detected_rate(detected_rate));
  // ====================================================================
  // Helpers
  function automatic logic [31:0] ctl(int r, int p, bit l, bit a);
    return {18'h0, a, l, 6'h0, 2'(p), 1'h0, 3'(r)};
  endfunction
  function automatic logic [31:0] cmd(bit run, bit clr, bit v,
                                      logic [15:0] s);
    return {s, 5'h0, v, 7'h0, clr, 1'h0, run};
  endfunction
  task automatic fail(string s);
    $display("[ERR] %0t %s", $time, s);
    n_mismatch++;
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(logic [15:0] g, logic [15:0] e, string s);
    tests_run++;
    if (g !== e) fail(s);
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = 2'h0,
                    bit slow = 1'h0);
    int n;
    n = 0;
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1;
    bready <= !slow;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (n == 3) bready <= 1'h1;
      n++;
    end while (!(bvalid && bready) && n < 50);
    bready <= 1'h0;
    if (n >= 50) begin fail("write hang"); test_done(); end
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e,
                    logic [31:0] k = 32'hFFFFFFFF, logic [1:0] r = 2'h0,
                    bit slow = 1'h0);
    int n;
    n = 0;
    rq.push_back({r, e});
    mq.push_back(k);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'h1; rready <= !slow;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (n == 3) rready <= 1'h1;
      n++;
    end while (!(rvalid && rready) && n < 50);
    rready <= 1'h0;
    if (n >= 50) begin fail("read hang"); test_done(); end
  endtask
  task automatic wait_sil(logic e);
    int n;
    for (n = 0; n < 3 * TICK && silence_active !== e; n++) @(posedge aclk);
    if (silence_active !== e) begin fail("silence wait"); test_done(); end
    tests_run++;
  endtask
  // ====================================================================
  // Result monitor
  always @(posedge aclk) begin
    if (bvalid && bready) begin
      tests_run++;
      if (bresp !== bq.pop_front()) fail("write response");
    end
    if (rvalid && rready) begin
      x = rq.pop_front();
      m = mq.pop_front();
      tests_run++;
      if (rresp !== x[33:32] || (rdata & m) !== (x[31:0] & m))
        fail("read data");
    end
  end
  initial begin
    idle(30000);
    fail("run timeout");
    test_done();
  end
  // ====================================================================
  // Scenarios
  initial begin
    sp = 16'($random(seed));
    idle(2);
    aresetn <= 1'h1;
    fault_req <= 1'h1;
    speed_set <= sp;
    rate_set <= (sp[1:0] == 2'h3) ? 2'h0 : sp[1:0];
    idle(4);
    rd(8'h00, 32'h2010, , , 1'h1);
    rd(8'h04, 32'h1);
    rd(8'h18, 32'h0CCD);
    rd(8'h14, 32'h14 + rate_set);
    rd(8'h0C, {sp, 16'h1}, 32'hFFFF0005);
    rd(8'h1C, 32'h0, , 2'h2);
    rd(8'h10, 32'hA0);
    wr(8'h0C, 32'h1, 2'h2, 1'h1);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h1);
    wr(8'h04, 32'h64);
    rd(8'h04, 32'h63);
    wr(8'h04, 32'h1);
    for (int rs = 1; rs < 4; rs++) begin
      wr(8'h00, ctl(0, 1, 0, 1) | (32'(rs) << 8));
      rd(8'h14, 32'(19 + rs));
    end
    wr(8'h00, ctl(1, 1, 0, 1));
    idle(3 * TICK);
    chk(silence_active, 1'h0, "armed early");
    fault_req <= 1'h0;
    for (int p = 0; p < 3; p++) for (int v = 0; v < 2; v++) begin
      sp = 16'($random(seed));
      wr(8'h00, ctl(0, p, 0, 1));
      wr(8'h08, cmd(0, 0, p != 2, 16'h0));
      idle(2);
      if (p == 2) chk(coast, 1'h1, "no coast");
      wr(8'h08, cmd(1, 0, v, sp));
      idle(2);
      chk(run_forward, p == 0 || (p == 1) == v, "run");
      chk(speed_reference, sp & {16{p == 0 || (p == 1) == v}}, "ref");
      if (p == 0) rd(8'h0C, 32'h4, 32'h5);
    end
    for (int r = 1; r < 8; r++) begin
      sp = 16'($random(seed));
      s2 = 16'($random(seed));
      wr(8'h00, ctl(r, 1, 0, 1));
      wr(8'h08, cmd(1, 0, 1, sp));
      wait_sil(1'h1);
      case (3'(r))
        REACT_HOLD: chk(speed_reference, sp, "hold");
        REACT_STOP: chk(run_forward, 1'h0, "stop");
        REACT_INCH: chk(speed_reference, 16'h0CCD, "inch");
        REACT_TOP: chk(speed_reference, 16'h4000, "top");
        REACT_TRIP: chk(trip_latched, 1'h1, "trip");
        REACT_RELEASE: chk(network_control, 1'h0, "release");
        default: chk(profile4_active, 1'h1, "profile");
      endcase
      if (r == 5) begin
        wr(8'h08, cmd(1, 0, 1, s2));
        idle(2);
        chk(silence_active, 1'h1, "trip left");
      end
      wr(8'h08, cmd(1, 1, 1, s2));
      idle(2);
      chk(silence_active, 1'h0, "no resume");
      chk(run_forward, 1'h1, "no restart");
      chk(speed_reference, s2, "resume ref");
      chk(trip_latched, 1'h0, "trip kept");
    end
    chk(profile4_active, 1'h1, "profile restored");
    for (int k = 0; k < 3; k++) begin
      wr(8'h00, ctl(1, 3, 0, 1));
      wr(8'h08, cmd(1, 0, 1, sp));
      wr(8'h08, cmd(1, 0, 0, sp));
      idle(2);
      chk(silence_active, 1'h1, "policy three");
      wr(8'h00, ctl(k != 2, 3, k == 0, k != 1));
      idle(2);
      chk(silence_active, 1'h0, "exit");
      chk(run_forward, k == 2, "exit run");
      if (k == 0) begin
        wr(8'h08, cmd(1, 0, 1, s2));
        idle(2);
        chk(run_forward, 1'h0, "local run");
      end
      wr(8'h00, ctl(1, 1, 0, 1));
      idle(3 * TICK);
      chk(silence_active, 1'h0, "rearmed");
    end
    rd(8'h08, cmd(1, 0, 0, sp));
    test_done();
  end
endmodule
